// ==== rtl/pbsp_ctl.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbsp_ctl (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_REQ,
	input wire logic I_WRITE,
	input wire logic I_BURST,
	input wire logic [pbsp_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [pbsp_pkg::DATA_W-1:0] I_WDATA,
	input wire logic [pbsp_pkg::LANES-1:0] I_BE_N,
	input wire logic I_STALL,
	input wire logic I_SLEEP,
	input wire logic I_ORDER,
	output logic O_BUSY,
	output logic O_RVALID,
	output logic [pbsp_pkg::DATA_W-1:0] O_RDATA,
	pbsp_if.ctl BUS
);
	logic [1:0] beats_r;
	logic burst_w_r;
	logic [1:0] wr_pipe_r;
	logic rd_pipe_r;
	logic [pbsp_pkg::DATA_W-1:0] wd1_r;
	logic [pbsp_pkg::DATA_W-1:0] wd2_r;
	logic [pbsp_pkg::DATA_W-1:0] wd3_r;
	logic cq_n_r;
	logic adv_r;
	logic sel_r;
	logic we_n_r;
	logic [pbsp_pkg::LANES-1:0] be_n_r;
	logic [pbsp_pkg::ADDR_W-1:0] addr_r;
	logic dq_oe_n_r;
	logic oe_n_r;
	logic issue;

	assign issue = !I_STALL && !I_SLEEP;

	// one command per edge; a burst sends three advances
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sel_r <= 1'b0;
			adv_r <= 1'b0;
			we_n_r <= 1'b1;
			be_n_r <= '1;
			addr_r <= '0;
			beats_r <= 2'h0;
			burst_w_r <= 1'b0;
			cq_n_r <= 1'b0;
			O_BUSY <= 1'b0;
		end else begin
			cq_n_r <= I_STALL;
			if (issue) begin
				if (beats_r != 2'h0) begin
					adv_r <= 1'b1;
					be_n_r <= I_BE_N;
					beats_r <= beats_r - 2'h1;
				end else begin
					adv_r <= 1'b0;
					sel_r <= I_REQ;
					we_n_r <= !I_WRITE;
					be_n_r <= I_BE_N;
					addr_r <= I_ADDR;
					burst_w_r <= I_WRITE;
					beats_r <= (I_REQ && I_BURST) ? 2'h3 : 2'h0;
				end
				O_BUSY <= (beats_r > 2'h1) || (beats_r == 2'h0 &&
					I_REQ && I_BURST);
			end
		end
	end

	// the device sees a command one edge after it is issued here and
	// takes write data two edges after that; oe is lowered only
	// while read data is due, so the device never drives otherwise
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			wr_pipe_r <= 2'h0;
			rd_pipe_r <= 1'b0;
			wd1_r <= '0;
			wd2_r <= '0;
			wd3_r <= '0;
			dq_oe_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= '0;
		end else if (!cq_n_r) begin
			wr_pipe_r <= {wr_pipe_r[0], issue &&
				((beats_r != 2'h0) ? burst_w_r : (I_REQ && I_WRITE))};
			rd_pipe_r <= issue &&
				((beats_r != 2'h0) ? !burst_w_r : (I_REQ && !I_WRITE));
			wd1_r <= I_WDATA;
			wd2_r <= wd1_r;
			wd3_r <= wd2_r;
			dq_oe_n_r <= !wr_pipe_r[1];
			oe_n_r <= !rd_pipe_r;
			O_RVALID <= !BUS.mem_dq_oe_n;
			O_RDATA <= BUS.dq;
		end else begin
			O_RVALID <= 1'b0;
		end
	end

	assign BUS.clock_qualify_n = cq_n_r;
	assign BUS.chip_select_1_n = !sel_r;
	assign BUS.chip_select_2 = sel_r;
	assign BUS.chip_select_3_n = !sel_r;
	assign BUS.advance_or_load = adv_r;
	assign BUS.write_n = we_n_r;
	assign BUS.byte_lane_write_n = be_n_r;
	assign BUS.output_enable_n = oe_n_r;
	assign BUS.sleep_request = I_SLEEP;
	assign BUS.burst_order = I_ORDER;
	assign BUS.addr = addr_r;
	assign BUS.ctl_dq_o = wd3_r;
	assign BUS.ctl_dq_oe_n = dq_oe_n_r;
endmodule
`default_nettype wire

// ==== rtl/pbsp_mem.sv ====
// Functional notes
// - inputs registered on rising clock edge
// - clock-qualify high freezes all state except the drive flag and the pin syncs
// - read starts: selected, write high, load
// - read data out one edge later
// - read data driven only with oe low
// - next op accepted; deselect pipelined
// - burst counter gives four accesses
// - strap picks linear or interleaved order
// - counter changes two low bits, wraps
// - advance ignores selects and write strobe
// - direction latched for the whole burst
// - write starts: selected, write strobe low
// - bus tristated the edge after write address
// - write data latched second edge later
// - only selected byte lanes written
// - controller avoids driving while device drives
// - controller gives byte selects each beat
// - controller loads after deselect
// - sleep preserves data, idles the device
// - interleaved order xors start offset
// - linear order increments modulo four
// - outputs tristate on write, deselect, first clock
// - power up deselected and tristated
`timescale 1ns/10ps
`default_nettype none
module pbsp_mem #(
	parameter int LANES = pbsp_pkg::LANES
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	pbsp_if.mem BUS
);
	localparam int DW = LANES * pbsp_pkg::LANE_W;
	logic [DW-1:0] mem_r [pbsp_pkg::DEPTH];
	logic sleep_s1_r;
	logic sleep_s2_r;
	logic mode_s1_r;
	logic mode_r;
	pbsp_pkg::pbsp_op_type op_r;
	pbsp_pkg::pbsp_op_type burst_dir_r;
	logic [pbsp_pkg::ADDR_W-1:0] base_r;
	logic [1:0] start_r;
	logic [1:0] step_r;
	logic wr_pend_r;
	logic [LANES-1:0] wr_lanes_n_r;
	logic [DW-1:0] wr_word;
	logic [DW-1:0] rd_word;
	logic [pbsp_pkg::ADDR_W-1:0] wr_addr_r;
	logic [LANES-1:0] wr_be_n_r;
	logic [DW-1:0] q_r;
	logic q_valid_r;
	logic drive_n_r;
	logic sel;
	logic run;
	logic [1:0] step_nxt;
	logic [pbsp_pkg::ADDR_W-1:0] cur_addr;

	function automatic logic [1:0] burst_ofs(input logic mode,
		input logic [1:0] start, input logic [1:0] step);
		if (mode) begin
			burst_ofs = start ^ step;
		end else begin
			burst_ofs = start + step;
		end
	endfunction

	// one lane of a word, data bits plus its parity bit
	function automatic logic [pbsp_pkg::LANE_W-1:0] lane_of(
		input logic [DW-1:0] word, input int idx);
		lane_of = word[idx*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W];
	endfunction

	// write strobe to direction, used for the op and the burst
	function automatic pbsp_pkg::pbsp_op_type dir_of(input logic wr_n);
		if (wr_n) begin
			dir_of = pbsp_pkg::PBSP_OP_READ;
		end else begin
			dir_of = pbsp_pkg::PBSP_OP_WRITE;
		end
	endfunction

	// sleep and the strap come from pins, so both pass two flops;
	// the cost is two edges of lag on entering and leaving sleep
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sleep_s1_r <= 1'b0;
			sleep_s2_r <= 1'b0;
			mode_s1_r <= 1'b0;
			mode_r <= 1'b0;
		end else begin
			sleep_s1_r <= BUS.sleep_request;
			sleep_s2_r <= sleep_s1_r;
			mode_s1_r <= BUS.burst_order;
			mode_r <= mode_s1_r;
		end
	end

	// sleep acts like a held clock-qualify, so stored data survives
	assign run = !BUS.clock_qualify_n && !sleep_s2_r;
	assign sel = !BUS.chip_select_1_n && BUS.chip_select_2 &&
		!BUS.chip_select_3_n;
	assign step_nxt = step_r + pbsp_pkg::OFS_STEP;
	assign cur_addr = {base_r[pbsp_pkg::ADDR_W-1:2],
		burst_ofs(mode_r, start_r, step_r)};

	// command stage: one op per qualified edge
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			op_r <= pbsp_pkg::PBSP_OP_IDLE;
			burst_dir_r <= pbsp_pkg::PBSP_OP_IDLE;
			base_r <= '0;
			start_r <= pbsp_pkg::OFS_ZERO;
			step_r <= pbsp_pkg::OFS_ZERO;
			wr_be_n_r <= '1;
		end else if (run) begin
			if (BUS.advance_or_load) begin
				// selects and write strobe ignored here
				op_r <= burst_dir_r;
				step_r <= step_nxt;
			end else if (sel) begin
				op_r <= dir_of(BUS.write_n);
				burst_dir_r <= dir_of(BUS.write_n);
				base_r <= BUS.addr;
				start_r <= BUS.addr[1:0];
				step_r <= pbsp_pkg::OFS_ZERO;
			end else begin
				op_r <= pbsp_pkg::PBSP_OP_IDLE;
				burst_dir_r <= pbsp_pkg::PBSP_OP_IDLE;
			end
			wr_be_n_r <= BUS.byte_lane_write_n;
		end
	end

	// a write beat waits one edge for its data; its lanes travel
	// with it, since the next op overwrites the captured selects
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
			wr_lanes_n_r <= '1;
		end else if (run) begin
			wr_pend_r <= op_r == pbsp_pkg::PBSP_OP_WRITE;
			wr_addr_r <= cur_addr;
			wr_lanes_n_r <= wr_be_n_r;
		end
	end

	// merged word: selected lanes from the bus, the rest as stored
	genvar g;
	for (g = 0; g < LANES; g++) begin : g_lane
		assign wr_word[g*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] =
			wr_lanes_n_r[g] ? lane_of(mem_r[wr_addr_r], g) :
			lane_of(BUS.dq, g);
	end

	// lanes with their parity bit, written at the second edge
	always_ff @(posedge I_CLK) begin
		if (run && wr_pend_r) begin
			mem_r[wr_addr_r] <= wr_word;
		end
	end

	// a read right behind a write to the same word sees the new
	// lanes; without this forward it would return stale data
	assign rd_word = (wr_pend_r && wr_addr_r == cur_addr) ? wr_word :
		mem_r[cur_addr];

	// read register loads on the edge after the address edge
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			q_r <= '0;
			q_valid_r <= 1'b0;
		end else if (sleep_s2_r) begin
			q_valid_r <= 1'b0;
		end else if (run) begin
			q_valid_r <= op_r == pbsp_pkg::PBSP_OP_READ;
			if (op_r == pbsp_pkg::PBSP_OP_READ) begin
				q_r <= rd_word;
			end
		end
	end

	// oe comes from logic on this clock, so no resync; it is taken
	// on the edge, so a change of oe shows one edge later
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			drive_n_r <= 1'b1;
		end else if (sleep_s2_r) begin
			drive_n_r <= 1'b1;
		end else if (run) begin
			drive_n_r <= !(op_r == pbsp_pkg::PBSP_OP_READ &&
				!BUS.output_enable_n);
		end else begin
			drive_n_r <= !(q_valid_r && !BUS.output_enable_n);
		end
	end

	assign BUS.mem_dq_oe_n = drive_n_r;
	assign BUS.mem_dq_o = DW'(q_r);
endmodule
`default_nettype wire

// ==== shared/pbsp_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface pbsp_if;
	logic clock_qualify_n;
	logic chip_select_1_n;
	logic chip_select_2;
	logic chip_select_3_n;
	logic advance_or_load;
	logic write_n;
	logic [pbsp_pkg::LANES-1:0] byte_lane_write_n;
	logic output_enable_n;
	logic sleep_request;
	logic burst_order;
	logic [pbsp_pkg::ADDR_W-1:0] addr;
	logic [pbsp_pkg::DATA_W-1:0] mem_dq_o;
	logic mem_dq_oe_n;
	logic [pbsp_pkg::DATA_W-1:0] ctl_dq_o;
	logic ctl_dq_oe_n;
	logic [pbsp_pkg::DATA_W-1:0] dq;
	always_comb begin
		if (!mem_dq_oe_n) begin
			dq = mem_dq_o;
		end else if (!ctl_dq_oe_n) begin
			dq = ctl_dq_o;
		end else begin
			dq = '0;
		end
	end
	modport mem (
		input clock_qualify_n, chip_select_1_n, chip_select_2,
		input chip_select_3_n, advance_or_load, write_n,
		input byte_lane_write_n, output_enable_n, sleep_request,
		input burst_order, addr, dq,
		output mem_dq_o, mem_dq_oe_n
	);
	modport ctl (
		output clock_qualify_n, chip_select_1_n, chip_select_2,
		output chip_select_3_n, advance_or_load, write_n,
		output byte_lane_write_n, output_enable_n, sleep_request,
		output burst_order, addr, ctl_dq_o, ctl_dq_oe_n,
		input dq, mem_dq_oe_n
	);
endinterface
`default_nettype wire

// ==== shared/pbsp_pkg.sv ====
package pbsp_pkg;
	localparam int ADDR_W = 8;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [1:0] OFS_STEP = 2'h1;
	localparam logic [1:0] OFS_ZERO = 2'h0;
	localparam int BURST_LEN = 4;
	typedef enum logic [1:0] {
		PBSP_OP_IDLE = 2'b00,
		PBSP_OP_READ = 2'b01,
		PBSP_OP_WRITE = 2'b10
	} pbsp_op_type;
endpackage

// ==== sim/pbsp_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbsp_sva (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic clock_qualify_n,
	input wire logic chip_select_1_n,
	input wire logic chip_select_2,
	input wire logic chip_select_3_n,
	input wire logic advance_or_load,
	input wire logic write_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic [pbsp_pkg::DATA_W-1:0] mem_dq_o,
	input wire logic mem_dq_oe_n,
	input wire logic ctl_dq_oe_n
);
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (!I_ARST_N);
	wire logic go = !clock_qualify_n && !sleep_request;
	wire logic sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	wire logic ld = go && !advance_or_load;
	wire logic wr = ld && sel && !write_n;
	wire logic rd = ld && sel && write_n;
	wire logic ds = ld && !sel;
	reset_idle_a:
	assert property ($rose(I_ARST_N) |-> mem_dq_oe_n)
		else $error("data bus driven right after reset");
	bus_clash_a:
	assert property (!(!mem_dq_oe_n && !ctl_dq_oe_n))
		else $error("both ends drive the data bus");
	desel_off_a:
	assert property (ds ##1 go |=> mem_dq_oe_n)
		else $error("memory drives after deselect");
	wr_tristate_a:
	assert property (wr ##1 go |=> mem_dq_oe_n)
		else $error("memory drives in write data cycle");
	wr_data_a:
	assert property (wr ##1 go |=> !ctl_dq_oe_n)
		else $error("controller gives no write data");
	// last beat of a burst read stands one edge after its advance
	rd_drive_a:
	assert property (rd ##1 (go && advance_or_load)[*3]
		##0 !output_enable_n ##1 go |-> !mem_dq_oe_n)
		else $error("read burst data not driven");
	oe_mask_a:
	assert property ((output_enable_n && go)[*4] |-> mem_dq_oe_n)
		else $error("memory drives with output enable high");
	stall_hold_a:
	assert property (clock_qualify_n && !sleep_request |=> $stable(mem_dq_o))
		else $error("output changed during stall");
	sleep_off_a:
	assert property (sleep_request[*3] |-> mem_dq_oe_n)
		else $error("memory drives while asleep");
endmodule
`default_nettype wire

// ==== sim/pbsp_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module pbsp_tb;
	logic clk, rst_n, req, wr, bst, stall, slp, ord, busy, rv;
	logic [pbsp_pkg::ADDR_W-1:0] adr;
	logic [pbsp_pkg::DATA_W-1:0] wd, rdat;
	logic [3:0] be_n;
	int fails, checked;
	pbsp_if bus ();
	pbsp_mem pbsp_mem_i (.I_CLK(clk), .I_ARST_N(rst_n), .BUS(bus));
	pbsp_ctl pbsp_ctl_i (.I_CLK(clk), .I_ARST_N(rst_n), .I_REQ(req),
		.I_WRITE(wr), .I_BURST(bst), .I_ADDR(adr), .I_WDATA(wd),
		.I_BE_N(be_n), .I_STALL(stall), .I_SLEEP(slp), .I_ORDER(ord),
		.O_BUSY(busy), .O_RVALID(rv), .O_RDATA(rdat), .BUS(bus));
	pbsp_sva pbsp_sva_i (.I_CLK(clk), .I_ARST_N(rst_n),
		.clock_qualify_n(bus.clock_qualify_n),
		.chip_select_1_n(bus.chip_select_1_n),
		.chip_select_2(bus.chip_select_2),
		.chip_select_3_n(bus.chip_select_3_n),
		.advance_or_load(bus.advance_or_load), .write_n(bus.write_n),
		.output_enable_n(bus.output_enable_n),
		.sleep_request(bus.sleep_request), .mem_dq_o(bus.mem_dq_o),
		.mem_dq_oe_n(bus.mem_dq_oe_n), .ctl_dq_oe_n(bus.ctl_dq_oe_n));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [35:0] pat(input logic [7:0] a);
		return {4{1'b1, a}};
	endfunction
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic stop_test;
		if (fails == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic op(input logic w, input logic b, input logic [7:0] a,
		input logic [35:0] d, input logic [3:0] be);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 50) begin
			@(posedge clk);
			#1 n++;
		end
		req = 1'b1;
		wr = w;
		bst = b;
		adr = a;
		wd = d;
		be_n = be;
		@(posedge clk);
		#1;
	endtask
	// waits from the next edge on, so one pulse is never counted twice
	task automatic get(input logic [35:0] exp);
		int n;
		n = 0;
		req = 1'b0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (rv !== 1'b1 && n < 40);
		if (rv !== 1'b1) begin
			fails++;
			stop_test();
		end
		chk(rdat, exp);
	endtask
	task automatic set_order(input logic o);
		ord = o;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic t_single;
		for (int i = 0; i < 8; i++) op(1, 0, 8'h10 + i, pat(8'h10 + i), 0);
		for (int i = 0; i < 8; i++) begin
			op(0, 0, 8'h10 + i, '0, 4'hf);
			get(pat(8'h10 + i));
		end
	endtask
	task automatic t_bytes;
		op(1, 0, 8'h40, '0, 4'h0);
		op(1, 0, 8'h40, '1, 4'ha);
		op(0, 0, 8'h40, '0, 4'hf);
		get({9'h0, 9'h1ff, 9'h0, 9'h1ff});
	endtask
	task automatic t_order;
		logic [1:0] s;
		for (int o = 0; o < 2; o++) begin
			set_order(o[0]);
			op(0, 1, 8'h11, '0, 4'hf);
			for (int j = 0; j < 4; j++) begin
				s = o ? 2'h1 ^ j[1:0] : 2'h1 + j[1:0];
				get(pat({6'h04, s}));
			end
		end
	endtask
	task automatic t_wrap;
		set_order(1'b0);
		op(1, 0, 8'h34, pat(8'h34), 0);
		op(1, 1, 8'h32, 36'h123456789, 0);
		for (int i = 0; i < 5; i++) begin
			op(0, 0, 8'h30 + i, '0, 4'hf);
			get(i < 4 ? 36'h123456789 : pat(8'h34));
		end
	endtask
	task automatic t_stall;
		op(0, 0, 8'h12, '0, 4'hf);
		req = 1'b0;
		stall = 1'b1;
		repeat (6) @(posedge clk);
		#1 stall = 1'b0;
		get(pat(8'h12));
	endtask
	task automatic t_sleep;
		slp = 1'b1;
		repeat (10) @(posedge clk);
		#1 slp = 1'b0;
		repeat (4) @(posedge clk);
		#1 op(0, 0, 8'h13, '0, 4'hf);
		get(pat(8'h13));
	endtask
	initial begin
		rst_n = 1'b0;
		req = 1'b0;
		wr = 1'b0;
		bst = 1'b0;
		adr = '0;
		wd = '0;
		be_n = '1;
		stall = 1'b0;
		slp = 1'b0;
		ord = 1'b0;
		fails = 0;
		checked = 0;
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(bus.mem_dq_oe_n, 1);
		t_single();
		t_bytes();
		t_order();
		t_wrap();
		t_stall();
		t_sleep();
		stop_test();
	end
endmodule
`default_nettype wire
